// File: shared/smsp_params.svh
`ifndef SMSP_PARAMS_SVH
`define SMSP_PARAMS_SVH

// array geometry: 2048 bytes of eight bits
`define SMSP_ADDR_W       11
`define SMSP_DEPTH        2048
`define SMSP_BYTE_W       8
`define SMSP_BIT_W        3
`define SMSP_LAST_BIT     3'h7

// timing: system clock and serial clock
`define SMSP_CLK_NS       20
`define SMSP_SCK_MIN_NS   50
`define SMSP_SCK_MIN_HALF ((`SMSP_SCK_MIN_NS / 2 + `SMSP_CLK_NS - 1) / `SMSP_CLK_NS)
`define SMSP_SCK_HALF_NS  160
`define SMSP_SCK_HALF     ((`SMSP_SCK_HALF_NS + `SMSP_CLK_NS - 1) / `SMSP_CLK_NS)

// command opcodes
`define SMSP_OP_WRITE_ENABLE       8'h06
`define SMSP_WRITE_DISABLE_COMMAND 8'h04
`define SMSP_OP_RD_STATUS          8'h05
`define SMSP_OP_WR_STATUS          8'h01
`define SMSP_OP_READ               8'h03
`define SMSP_OP_WRITE              8'h02

// status byte layout
`define SMSP_SR_PROT_PIN_EN 7
`define SMSP_SR_BP_HI       3
`define SMSP_SR_BP_LO       2
`define SMSP_SR_WEL         1
`define SMSP_BP_NONE        2'h0
`define SMSP_BP_QUARTER     2'h1
`define SMSP_BP_HALF        2'h2

// link input synchroniser lanes and their idle levels
`define SMSP_SYN_W   5
`define SMSP_SYN_CS  4
`define SMSP_SYN_SCK 3
`define SMSP_SYN_SI  2
`define SMSP_SYN_HLD 1
`define SMSP_SYN_WP  0
`define SMSP_SYN_RST 5'h13

// host side framing and buffering
`define SMSP_HDR_OP   2'h1
`define SMSP_HDR_ADDR 2'h3
`define SMSP_LEN_W    8
`define SMSP_FIFO_W   8
`define SMSP_FIFO_DEPTH 16

`endif

// File: shared/smsp_pkg.sv
package smsp_pkg;

  // device protocol states
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_OPC  = 9'h002,
    ST_ADH  = 9'h004,
    ST_ADL  = 9'h008,
    ST_WR   = 9'h010,
    ST_RD   = 9'h020,
    ST_SRW  = 9'h040,
    ST_SRR  = 9'h080,
    ST_IGN  = 9'h100
  } smsp_dev_e;

  // host sequencer states
  typedef enum logic [4:0] {
    H_IDLE  = 5'h01,
    H_SEL   = 5'h02,
    H_LOAD  = 5'h04,
    H_BIT   = 5'h08,
    H_DESEL = 5'h10
  } smsp_host_e;

endpackage

// File: shared/smsp_link_if.sv
`timescale 1ns/100ps
// four-wire serial link plus pause and write-protect pins
interface smsp_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic hold_n;
  logic wp_n;
  logic miso_o;
  logic miso_oe;
  logic miso;

  // released output line reads high through the bus pull-up
  assign miso = miso_oe ? miso_o : 1'b1;

  modport dev (
    input  cs_n, sck, mosi, hold_n, wp_n,
    output miso_o, miso_oe
  );
  modport host (
    output cs_n, sck, mosi, hold_n, wp_n,
    input  miso
  );
endinterface

// File: rtl/smsp_dev.sv
`timescale 1ns/100ps
`include "smsp_params.svh"
// Overview of operation
// - chip select high: standby, output released
// - each opcode needs fresh chip select fall
// - sample on rising, shift out on falling
// - serial clock static, zero to 20 MHz
// - serial input only counts at rising edges
// - output driven only during reads, not paused
// - pin enable plus low protect pin blocks status
// - pause freezes operation, ignores clock and select
// - master moves pause only while clock low
// - each write byte lands when complete
// - array of 2048 eight-bit locations
// - only modes 0 and 3 supported
// - block protection for quarter, half, all
// - write disable blocks array and status writes
// - clock ignored while chip select high
// - two address bytes, low 11 bits used
// - first byte after select is opcode
// - unknown opcode: ignore until next select
module smsp_dev
  import smsp_pkg::*;
#(
  parameter int ADDR_W = `SMSP_ADDR_W,
  parameter int DEPTH  = `SMSP_DEPTH
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  // serial link
  smsp_link_if.dev               link,
  // user-side observation
  output logic                   o_selected,
  output logic [7:0]             o_status,
  output logic                   o_wr_pulse,
  output logic [ADDR_W-1:0]      o_wr_addr
);

  logic [`SMSP_SYN_W-1:0] sync1_reg;
  logic [`SMSP_SYN_W-1:0] sync2_reg;
  logic                   cs_s;
  logic                   sck_s;
  logic                   mosi_s;
  logic                   hold_s;
  logic                   wp_s;
  logic                   sck_d_reg;
  logic                   cs_d_reg;
  logic                   sck_rise;
  logic                   sck_fall;
  logic                   cs_fall;
  logic                   cs_high;
  smsp_dev_e              state_reg;
  logic [`SMSP_BIT_W-1:0] bit_cnt_reg;
  logic [7:0]             in_sh_reg;
  logic [7:0]             rx_byte;
  logic                   byte_done;
  logic                   shifting;
  logic                   cmd_wr_reg;
  logic [ADDR_W-1:0]      addr_reg;
  logic [ADDR_W-1:0]      rd_idx;
  logic [7:0]             out_sh_reg;
  logic                   so_reg;
  logic                   oe_reg;
  logic                   wel_reg;
  logic                   protect_pin_enable_reg;
  logic [1:0]             bp_reg;
  logic [7:0]             status;
  logic [7:0]             mem_reg [DEPTH];
  logic                   blocked;
  logic                   mem_wr;
  logic                   sr_wr;
  logic                   wr_pulse_reg;
  logic [ADDR_W-1:0]      wr_addr_reg;

  // two-stage synchronisers for every link input
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      sync1_reg <= `SMSP_SYN_RST;
      sync2_reg <= `SMSP_SYN_RST;
    end else begin
      sync1_reg <= {link.cs_n, link.sck, link.mosi, link.hold_n, link.wp_n};
      sync2_reg <= sync1_reg;
    end
  end

  assign cs_s   = sync2_reg[`SMSP_SYN_CS];
  assign sck_s  = sync2_reg[`SMSP_SYN_SCK];
  assign mosi_s = sync2_reg[`SMSP_SYN_SI];
  assign hold_s = sync2_reg[`SMSP_SYN_HLD];
  assign wp_s   = sync2_reg[`SMSP_SYN_WP];

  // previous levels for edge finding; select edges wait out a pause
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      sck_d_reg <= 1'b0;
      cs_d_reg  <= 1'b1;
    end else begin
      sck_d_reg <= sck_s;
      if (hold_s) begin
        cs_d_reg <= cs_s;
      end
    end
  end

  // clock edges count only while selected and not paused
  assign sck_rise = sck_s & ~sck_d_reg & hold_s & ~cs_s;
  assign sck_fall = ~sck_s & sck_d_reg & hold_s & ~cs_s;
  assign cs_fall  = ~cs_s & cs_d_reg & hold_s;
  assign cs_high  = cs_s & hold_s;

  // incoming byte assembly, msb first
  assign rx_byte   = {in_sh_reg[6:0], mosi_s};
  assign shifting  = sck_rise & (state_reg != ST_IDLE) & (state_reg != ST_IGN);
  assign byte_done = shifting & (bit_cnt_reg == `SMSP_LAST_BIT);

  // protocol sequencer
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= '0;
      in_sh_reg   <= 8'h00;
      cmd_wr_reg  <= 1'b0;
      addr_reg    <= '0;
    end else if (cs_high) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= '0;
    end else if (cs_fall) begin
      state_reg   <= ST_OPC;
      bit_cnt_reg <= '0;
    end else if (shifting) begin
      in_sh_reg   <= rx_byte;
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
      if (byte_done) begin
        case (state_reg)
          ST_OPC: begin
            case (rx_byte)
              `SMSP_OP_READ, `SMSP_OP_WRITE: begin
                state_reg  <= ST_ADH;
                cmd_wr_reg <= (rx_byte == `SMSP_OP_WRITE);
              end
              `SMSP_OP_RD_STATUS: state_reg <= ST_SRR;
              `SMSP_OP_WR_STATUS: state_reg <= ST_SRW;
              default: state_reg <= ST_IGN;
            endcase
          end
          ST_ADH: begin
            addr_reg[ADDR_W-1:8] <= rx_byte[ADDR_W-9:0];
            state_reg            <= ST_ADL;
          end
          ST_ADL: begin
            addr_reg[7:0] <= rx_byte;
            state_reg     <= cmd_wr_reg ? ST_WR : ST_RD;
          end
          ST_WR, ST_RD: begin
            addr_reg <= addr_reg + 1'b1;
          end
          ST_SRW: state_reg <= ST_IGN;
          ST_SRR: state_reg <= ST_SRR;
          default: state_reg <= ST_IGN;
        endcase
      end
    end
  end

  // block protection region decode
  always_comb begin
    case (bp_reg)
      `SMSP_BP_NONE:    blocked = 1'b0;
      `SMSP_BP_QUARTER: blocked = &addr_reg[ADDR_W-1:ADDR_W-2];
      `SMSP_BP_HALF:    blocked = addr_reg[ADDR_W-1];
      default:          blocked = 1'b1;
    endcase
  end

  // write qualifiers for array and status
  assign mem_wr = byte_done & (state_reg == ST_WR) & wel_reg & ~blocked;
  assign sr_wr  = byte_done & (state_reg == ST_SRW) & wel_reg
                & ~(protect_pin_enable_reg & ~wp_s);

  // byte-immediate array storage
  always_ff @(posedge i_clk) begin
    if (mem_wr) begin
      mem_reg[addr_reg] <= rx_byte;
    end
  end

  // write report toward the user side
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      wr_pulse_reg <= 1'b0;
      wr_addr_reg  <= '0;
    end else begin
      wr_pulse_reg <= mem_wr;
      if (mem_wr) begin
        wr_addr_reg <= addr_reg;
      end
    end
  end

  // write latch and status configuration bits
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      wel_reg                <= 1'b0;
      protect_pin_enable_reg <= 1'b0;
      bp_reg                 <= `SMSP_BP_NONE;
    end else if (byte_done && state_reg == ST_OPC) begin
      if (rx_byte == `SMSP_OP_WRITE_ENABLE) begin
        wel_reg <= 1'b1;
      end else if (rx_byte == `SMSP_WRITE_DISABLE_COMMAND) begin
        wel_reg <= 1'b0;
      end
    end else if (sr_wr) begin
      protect_pin_enable_reg <= rx_byte[`SMSP_SR_PROT_PIN_EN];
      bp_reg <= rx_byte[`SMSP_SR_BP_HI:`SMSP_SR_BP_LO];
    end
  end

  // status byte image, unused bits read zero
  always_comb begin
    status                                  = 8'h00;
    status[`SMSP_SR_PROT_PIN_EN]            = protect_pin_enable_reg;
    status[`SMSP_SR_BP_HI:`SMSP_SR_BP_LO]   = bp_reg;
    status[`SMSP_SR_WEL]                    = wel_reg;
  end

  // read index: first byte at the fresh address, then sequential
  assign rd_idx = (state_reg == ST_ADL) ? {addr_reg[ADDR_W-1:8], rx_byte}
                                        : addr_reg + 1'b1;

  // outgoing shifter, loaded at a byte's last rising edge, shifts only on falling edges
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      out_sh_reg <= 8'h00;
      so_reg     <= 1'b0;
      oe_reg     <= 1'b0;
    end else if (cs_high) begin
      oe_reg <= 1'b0;
    end else if (byte_done && ((state_reg == ST_ADL && !cmd_wr_reg)
                               || state_reg == ST_RD)) begin
      out_sh_reg <= mem_reg[rd_idx];
    end else if (byte_done && (state_reg == ST_SRR || (state_reg == ST_OPC
                               && rx_byte == `SMSP_OP_RD_STATUS))) begin
      out_sh_reg <= status;
    end else if (sck_fall && (state_reg == ST_RD || state_reg == ST_SRR)) begin
      so_reg     <= out_sh_reg[7];
      out_sh_reg <= {out_sh_reg[6:0], 1'b0};
      oe_reg     <= 1'b1;
    end
  end

  // pin drive: released whenever paused or not returning data
  assign link.miso_o  = so_reg;
  assign link.miso_oe = oe_reg & hold_s & ~cs_s;

  assign o_selected = ~cs_s;
  assign o_status   = status;
  assign o_wr_pulse = wr_pulse_reg;
  assign o_wr_addr  = wr_addr_reg;

endmodule

// File: rtl/smsp_host.sv
`timescale 1ns/100ps
`include "smsp_params.svh"
// write-data buffer between user and serial engine
module smsp_fifo #(
  parameter int WIDTH = `SMSP_FIFO_W,
  parameter int DEPTH = `SMSP_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  // fill side
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  // drain side
  output logic [WIDTH-1:0]      o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;

  // full when pointers differ only in the wrap bit
  assign o_ready = ~((wr_ptr_reg[AW] != rd_ptr_reg[AW])
                   && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
  assign o_valid = (wr_ptr_reg != rd_ptr_reg);
  assign o_data  = mem_reg[rd_ptr_reg[AW-1:0]];

  // storage
  always_ff @(posedge i_clk) begin
    if (i_valid && o_ready) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= i_data;
    end
  end

  // pointers
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (i_valid && o_ready) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (o_valid && i_ready) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

// serial master: mode 0 clock made by dividing the system clock
module smsp_host
  import smsp_pkg::*;
#(
  parameter int HALF  = `SMSP_SCK_HALF,
  parameter int LEN_W = `SMSP_LEN_W
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  // serial link
  smsp_link_if.host             link,
  // command
  input  wire logic             i_start,
  input  wire logic [7:0]       i_op,
  input  wire logic [15:0]      i_addr,
  input  wire logic [LEN_W-1:0] i_len,
  output logic                  o_busy,
  output logic                  o_done,
  // write data stream
  input  wire logic [7:0]       i_wdata,
  input  wire logic             i_wvalid,
  output logic                  o_wready,
  // read data stream
  output logic [7:0]            o_rdata,
  output logic                  o_rvalid,
  // side pins
  input  wire logic             i_pause,
  input  wire logic             i_wp_n
);
  localparam int CW = $clog2(HALF) + 1;

  smsp_host_e       state_reg;
  logic [CW-1:0]    div_reg;
  logic [2:0]       bit_cnt_reg;
  logic [7:0]       tx_sh_reg;
  logic [7:0]       rx_sh_reg;
  logic [LEN_W:0]   idx_reg;
  logic [LEN_W:0]   total_reg;
  logic [1:0]       hdr_reg;
  logic [1:0]       start_hdr;
  logic [7:0]       op_reg;
  logic [15:0]      addr_reg;
  logic             sck_reg;
  logic             cs_n_reg;
  logic             mosi_reg;
  logic             hold_n_reg;
  logic             wp_n_reg;
  logic             miso1_reg;
  logic             miso2_reg;
  logic [7:0]       rdata_reg;
  logic             rvalid_reg;
  logic             done_reg;
  logic             half_end;
  logic             frz;
  logic             wtype;
  logic             in_data;
  logic             load_ok;
  logic [7:0]       load_byte;
  logic [7:0]       f_data;
  logic             f_valid;
  logic             f_pop;

  // buffered write bytes; engine stalls the clock while it is empty and a write data byte is due
  smsp_fifo #(
    .WIDTH (`SMSP_FIFO_W),
    .DEPTH (`SMSP_FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_data  (i_wdata),
    .i_valid (i_wvalid),
    .o_ready (o_wready),
    .o_data  (f_data),
    .o_valid (f_valid),
    .i_ready (f_pop)
  );

  // command decode helpers
  assign start_hdr = (i_op == `SMSP_OP_READ || i_op == `SMSP_OP_WRITE)
                   ? `SMSP_HDR_ADDR : `SMSP_HDR_OP;
  assign wtype     = (op_reg == `SMSP_OP_WRITE || op_reg == `SMSP_OP_WR_STATUS);
  assign in_data   = (idx_reg >= {{(LEN_W-1){1'b0}}, hdr_reg});
  assign half_end  = (div_reg == CW'(HALF - 1));
  assign frz       = ~sck_reg & (i_pause | ~hold_n_reg);
  assign f_pop     = (state_reg == H_LOAD) & in_data & wtype;

  // next byte to shift: address bytes, then data or filler
  always_comb begin
    load_ok   = 1'b1;
    load_byte = 8'h00;
    if (!in_data) begin
      load_byte = (idx_reg[0]) ? addr_reg[15:8] : addr_reg[7:0];
    end else if (wtype) begin
      load_byte = f_data;
      load_ok   = f_valid;
    end
  end

  // pause pin moves only while the clock is low
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      hold_n_reg <= 1'b1;
      wp_n_reg   <= 1'b1;
    end else begin
      wp_n_reg <= i_wp_n;
      if (!sck_reg) begin
        hold_n_reg <= ~i_pause;
      end
    end
  end

  // returned data synchroniser
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      miso1_reg <= 1'b1;
      miso2_reg <= 1'b1;
    end else begin
      miso1_reg <= link.miso;
      miso2_reg <= miso1_reg;
    end
  end

  // frame sequencer and bit engine
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_reg   <= H_IDLE;
      div_reg     <= '0;
      bit_cnt_reg <= '0;
      tx_sh_reg   <= 8'h00;
      rx_sh_reg   <= 8'h00;
      idx_reg     <= '0;
      total_reg   <= '0;
      hdr_reg     <= `SMSP_HDR_OP;
      op_reg      <= 8'h00;
      addr_reg    <= 16'h0000;
      sck_reg     <= 1'b0;
      cs_n_reg    <= 1'b1;
      mosi_reg    <= 1'b0;
      rdata_reg   <= 8'h00;
      rvalid_reg  <= 1'b0;
      done_reg    <= 1'b0;
    end else begin
      rvalid_reg <= 1'b0;
      done_reg   <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          if (i_start) begin
            op_reg    <= i_op;
            addr_reg  <= i_addr;
            hdr_reg   <= start_hdr;
            total_reg <= {1'b0, i_len} + {{(LEN_W-1){1'b0}}, start_hdr};
            idx_reg   <= '0;
            tx_sh_reg <= i_op;
            mosi_reg  <= i_op[7];
            cs_n_reg  <= 1'b0;
            div_reg   <= '0;
            state_reg <= H_SEL;
          end
        end
        H_SEL: begin
          div_reg <= div_reg + 1'b1;
          if (half_end) begin
            div_reg   <= '0;
            state_reg <= H_BIT;
          end
        end
        H_LOAD: begin
          if (load_ok) begin
            tx_sh_reg <= load_byte;
            mosi_reg  <= load_byte[7];
            div_reg   <= '0;
            state_reg <= H_BIT;
          end
        end
        H_BIT: begin
          if (frz) begin
            // restart the low phase so returned data settles after a pause
            div_reg <= '0;
          end else if (!half_end) begin
            div_reg <= div_reg + 1'b1;
          end else if (!frz && !sck_reg) begin
            div_reg   <= '0;
            sck_reg   <= 1'b1;
            rx_sh_reg <= {rx_sh_reg[6:0], miso2_reg};
          end else if (!frz) begin
            div_reg     <= '0;
            sck_reg     <= 1'b0;
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            if (bit_cnt_reg == `SMSP_LAST_BIT) begin
              idx_reg <= idx_reg + 1'b1;
              if (in_data && !wtype) begin
                rdata_reg  <= rx_sh_reg;
                rvalid_reg <= 1'b1;
              end
              state_reg <= (idx_reg + 1'b1 == total_reg) ? H_DESEL : H_LOAD;
            end else begin
              tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
              mosi_reg  <= tx_sh_reg[6];
            end
          end
        end
        H_DESEL: begin
          div_reg <= div_reg + 1'b1;
          if (half_end) begin
            div_reg <= '0;
            if (cs_n_reg) begin
              state_reg <= H_IDLE;
              done_reg  <= 1'b1;
            end else begin
              cs_n_reg <= 1'b1;
            end
          end
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  assign link.cs_n   = cs_n_reg;
  assign link.sck    = sck_reg;
  assign link.mosi   = mosi_reg;
  assign link.hold_n = hold_n_reg;
  assign link.wp_n   = wp_n_reg;
  assign o_busy      = (state_reg != H_IDLE);
  assign o_done      = done_reg;
  assign o_rdata     = rdata_reg;
  assign o_rvalid    = rvalid_reg;

endmodule

// File: bench/smsp_link_chk.sv
`timescale 1ns/100ps
// link checker: watches the wires between host and device
module smsp_link_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // link wires
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  logic [3:0] since_fall_reg;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  // cycles since the serial clock last fell, saturating
  always_ff @(posedge i_clk) begin
    if (!i_nrst || $fell(sck))
      since_fall_reg <= 4'h0;
    else if (since_fall_reg != 4'hF)
      since_fall_reg <= since_fall_reg + 4'h1;
  end

  idle_release_a: assert property (cs_n [*4] |-> !miso_oe)
    else $error("output driven while deselected");
  pause_release_a: assert property (!hold_n [*4] |-> !miso_oe)
    else $error("output driven while paused");
  drive_gate_a: assert property ($rose(miso_oe) |-> !cs_n && hold_n)
    else $error("output enabled outside a selected frame");
  out_edge_a: assert property (miso_oe && $changed(miso_o)
    |-> since_fall_reg <= 4'h5)
    else $error("output changed away from a clock fall");
  in_stable_a: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("data moved while clock high");
  mode_zero_a: assert property (cs_n |-> !sck)
    else $error("clock high while deselected");
  fresh_select_a: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("deselect too short");
  clock_high_a: assert property ($rose(sck) |-> sck [*4])
    else $error("clock high phase short");
  clock_low_a: assert property ($fell(sck) |-> !sck [*4])
    else $error("clock low phase short");
  pause_move_a: assert property ($changed(hold_n) |-> !sck)
    else $error("pause moved while clock high");

  // main scenarios reached
  read_seen_c: cover property ($rose(miso_oe));
  pause_seen_c: cover property ($fell(hold_n));
  protect_seen_c: cover property ($fell(wp_n) ##[1:900] $fell(cs_n));
endmodule

// File: bench/smsp_tb_top.sv
`timescale 1ns/100ps
module smsp_tb_top;
  import smsp_pkg::*;
  logic        i_clk, i_nrst, start, busy, done, wvalid, wready;
  logic        rvalid, pause, wp_n, selected, wr_pulse;
  logic [7:0]  op, len, wdata, rdata, status;
  logic [15:0] addr, cnt0, wr_cnt;
  logic [10:0] wr_addr;
  logic [7:0]  rq[$];
  int          miscompares, comparisons, i;

  smsp_link_if link ();
  smsp_host #(.HALF(8)) u_smsp_host (.i_clk(i_clk), .i_nrst(i_nrst),
    .link(link), .i_start(start), .i_op(op), .i_addr(addr), .i_len(len),
    .o_busy(busy), .o_done(done), .i_wdata(wdata), .i_wvalid(wvalid),
    .o_wready(wready), .o_rdata(rdata), .o_rvalid(rvalid),
    .i_pause(pause), .i_wp_n(wp_n));
  smsp_dev u_smsp_dev (.i_clk(i_clk), .i_nrst(i_nrst), .link(link),
    .o_selected(selected), .o_status(status), .o_wr_pulse(wr_pulse),
    .o_wr_addr(wr_addr));
  smsp_link_chk u_smsp_link_chk (.i_clk(i_clk), .i_nrst(i_nrst),
    .cs_n(link.cs_n), .sck(link.sck), .mosi(link.mosi),
    .hold_n(link.hold_n), .wp_n(link.wp_n), .miso_o(link.miso_o),
    .miso_oe(link.miso_oe), .miso(link.miso));

  // 50 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // committed array bytes
  initial wr_cnt = 16'h0000;
  always @(posedge i_clk) if (wr_pulse === 1'b1) wr_cnt <= wr_cnt + 16'h1;

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask

  // one frame: start, then gather read bytes until done
  task automatic cmd(input logic [7:0] o, input logic [15:0] a,
                     input logic [7:0] n);
    int k;
    rq.delete();
    op = o;
    addr = a;
    len = n;
    start = 1'b1;
    @(negedge i_clk);
    start = 1'b0;
    for (k = 0; k < 8000 && done !== 1'b1; k++) begin
      @(negedge i_clk);
      if (rvalid === 1'b1) rq.push_back(rdata);
    end
    chk({15'h0, done}, 16'h0001);
  endtask

  task automatic push(input logic [7:0] d);
    wdata = d;
    wvalid = 1'b1;
    @(negedge i_clk);
    wvalid = 1'b0;
  endtask

  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (60000) @(posedge i_clk);
    miscompares++;
    print_verdict();
  end

  // test sequence
  initial begin
    i_nrst = 1'b0;
    {start, op, addr, len, wdata, wvalid, pause} = '0;
    wp_n = 1'b1;
    repeat (4) @(negedge i_clk);
    i_nrst = 1'b1;
    cmd(8'h06, 16'h0, 8'h0);
    cmd(8'h05, 16'h0, 8'h1);
    chk({8'h0, rq[0]}, 16'h0002);
    // fill the buffer until it refuses
    wvalid = 1'b1;
    for (i = 0; i < 16; i++) begin
      wdata = 8'hA0 + i[7:0];
      @(negedge i_clk);
    end
    wvalid = 1'b0;
    chk({15'h0, wready}, 16'h0);
    cnt0 = wr_cnt;
    cmd(8'h02, 16'hFFF8, 8'd16);
    chk(wr_cnt - cnt0, 16'd16);
    chk({5'h0, wr_addr}, 16'h0007);
    // read back across the wrap with a pause in mid-frame
    fork
      cmd(8'h03, 16'h07F8, 8'd16);
      begin
        repeat (700) @(negedge i_clk);
        pause = 1'b1;
        repeat (60) @(negedge i_clk);
        pause = 1'b0;
      end
    join
    for (i = 0; i < 16; i++) chk({8'h0, rq[i]}, 16'hA0 + i[15:0]);
    cmd(8'hAA, 16'h0, 8'h1);
    chk({8'h0, rq[0]}, 16'h00FF);
    push(8'h84);
    cmd(8'h01, 16'h0, 8'h1);
    cmd(8'h05, 16'h0, 8'h1);
    chk({8'h0, rq[0]}, 16'h0086);
    cnt0 = wr_cnt;
    push(8'h55);
    cmd(8'h02, 16'h0700, 8'h1);
    chk(wr_cnt, cnt0);
    push(8'h56);
    cmd(8'h02, 16'h0100, 8'h1);
    chk(wr_cnt, cnt0 + 16'h1);
    chk({5'h0, wr_addr}, 16'h0100);
    wp_n = 1'b0;
    push(8'h00);
    cmd(8'h01, 16'h0, 8'h1);
    cmd(8'h05, 16'h0, 8'h1);
    chk({8'h0, rq[0]}, 16'h0086);
    wp_n = 1'b1;
    cmd(8'h04, 16'h0, 8'h0);
    chk({8'h0, status}, 16'h0084);
    cnt0 = wr_cnt;
    push(8'h11);
    cmd(8'h02, 16'h0100, 8'h1);
    chk(wr_cnt, cnt0);
    chk({15'h0, selected}, 16'h0);
    chk({15'h0, busy}, 16'h0);
    print_verdict();
  end
endmodule
